// [core/dsa_top.sv]
// Dual converter digital core: conversion control, serial readout, AXI regs.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module dsa_top
    import dsa_pkg::*;
(
    input  logic                core_clk,
    input  logic                reset,
    input  logic                conversion_start,
    input  logic                sck_p,
    input  logic                sck_n,
    input  logic                io_sel_level,
    input  logic                io_sel_floating,
    output logic                ch1_serial_out_p,
    output logic                ch1_serial_out_n,
    output logic                ch2_serial_out_p,
    output logic                ch2_serial_out_n,
    output logic                echoed_data_clock_p,
    input  logic                echoed_data_clock_n_in,
    output logic                echoed_data_clock_n_out,
    output logic                echoed_data_clock_n_oe,
    input  logic [ADDR_W-1:0]   s_axi_awaddr,
    input  logic                s_axi_awvalid,
    output logic                s_axi_awready,
    input  logic [DATA_W-1:0]   s_axi_wdata,
    input  logic [3:0]          s_axi_wstrb,
    input  logic                s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  logic                s_axi_bready,
    input  logic [ADDR_W-1:0]   s_axi_araddr,
    input  logic                s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [DATA_W-1:0]   s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  logic                s_axi_rready
);
    logic [5:0]          pins_sync;
    logic                cnv_prev_r;
    logic                sck_prev_r;
    dsa_io_mode_t        mode_r;
    logic [CODE_W-1:0]   sh1_r;
    logic [CODE_W-1:0]   sh2_r;
    logic [IN_W-1:0]     ch1_in_r;
    logic [IN_W-1:0]     ch2_in_r;
    logic [DATA_W-1:0]   conv_count_r;
    logic [CODE_W-1:0]   code1;
    logic [CODE_W-1:0]   code2;
    logic                busy1;
    logic                busy2;
    logic                ready1;
    logic                ready2;
    logic                aw_held_r;
    logic [ADDR_W-1:0]   aw_addr_r;
    logic                w_held_r;
    logic [DATA_W-1:0]   w_data_r;
    logic [3:0]          w_strb_r;

    dsa_sync2 #(
        .W(6)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({conversion_start, sck_p, sck_n, io_sel_level,
                    io_sel_floating, echoed_data_clock_n_in}),
        .sync_out (pins_sync)
    );

    wire cnv_lvl    = pins_sync[5];
    wire sck_p_lvl  = pins_sync[4];
    wire sck_n_lvl  = pins_sync[3];
    wire sel_lvl    = pins_sync[2];
    wire sel_float  = pins_sync[1];
    wire echo_n_lvl = pins_sync[0];

    // Low-power LVDS differs only in drive strength and its status mode code, not in pin logic.
    wire dsa_io_mode_t mode_nxt = sel_float ? io_lvds_lp :
                                  sel_lvl   ? io_lvds : io_cmos;
    wire is_lvds = (mode_r != io_cmos);

    // The start edge is taken from the positive pin alone.
    wire cnv_fall = cnv_prev_r & ~cnv_lvl;
    wire sck_lvl  = is_lvds ? (sck_p_lvl & ~sck_n_lvl) : sck_p_lvl;
    wire sck_rise = sck_lvl & ~sck_prev_r;
    wire sck_fall = ~sck_lvl & sck_prev_r;

    // The echo pin is an input only while CMOS leaves it undriven.
    wire echo_on = is_lvds | ~echo_n_lvl;

    // A start edge loads the previous result so readout overlaps conversion.
    wire [CODE_W-1:0] sh1_nxt = cnv_fall ? code1 :
                                sck_fall ? {sh1_r[CODE_W-2:0], 1'b0} : sh1_r;
    wire [CODE_W-1:0] sh2_nxt = cnv_fall ? code2 :
                                sck_fall ? {sh2_r[CODE_W-2:0], 1'b0} : sh2_r;

    dsa_sar_chan u_ch1 (
        .core_clk (core_clk),
        .reset    (reset),
        .hold     (cnv_fall),
        .step     (sck_rise),
        .sample   (ch1_in_r),
        .code_r   (code1),
        .busy     (busy1),
        .ready    (ready1)
    );

    dsa_sar_chan u_ch2 (
        .core_clk (core_clk),
        .reset    (reset),
        .hold     (cnv_fall),
        .step     (sck_rise),
        .sample   (ch2_in_r),
        .code_r   (code2),
        .busy     (busy2),
        .ready    (ready2)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnv_prev_r   <= 1'b0;
            sck_prev_r   <= 1'b0;
            mode_r       <= io_cmos;
            sh1_r        <= CODE_ZERO;
            sh2_r        <= CODE_ZERO;
            conv_count_r <= '0;
        end else begin
            cnv_prev_r <= cnv_lvl;
            sck_prev_r <= sck_lvl;
            mode_r     <= mode_nxt;
            sh1_r      <= sh1_nxt;
            sh2_r      <= sh2_nxt;
            if (cnv_fall) begin
                conv_count_r <= conv_count_r + 32'h0000_0001;
            end
        end
    end

    // Data and echo clock update on the same edge so they stay matched.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ch1_serial_out_p        <= 1'b0;
            ch1_serial_out_n        <= 1'b0;
            ch2_serial_out_p        <= 1'b0;
            ch2_serial_out_n        <= 1'b0;
            echoed_data_clock_p     <= 1'b0;
            echoed_data_clock_n_out <= 1'b0;
            echoed_data_clock_n_oe  <= 1'b0;
        end else begin
            ch1_serial_out_p        <= sh1_nxt[CODE_W-1];
            ch2_serial_out_p        <= sh2_nxt[CODE_W-1];
            ch1_serial_out_n        <= is_lvds & ~sh1_nxt[CODE_W-1];
            ch2_serial_out_n        <= is_lvds & ~sh2_nxt[CODE_W-1];
            echoed_data_clock_p     <= echo_on & sck_lvl;
            echoed_data_clock_n_out <= is_lvds & ~sck_lvl;
            echoed_data_clock_n_oe  <= is_lvds;
        end
    end

    wire do_wr    = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire wr_ch1   = (aw_addr_r == ADDR_CH1_INPUT);
    wire wr_ch2   = (aw_addr_r == ADDR_CH2_INPUT);
    wire wr_ro    = (aw_addr_r == ADDR_STATUS) |
                    (aw_addr_r == ADDR_CH1_RESULT) |
                    (aw_addr_r == ADDR_CH2_RESULT) |
                    (aw_addr_r == ADDR_CONV_COUNT);
    wire wr_hit   = wr_ch1 | wr_ch2 | wr_ro;
    wire [IN_W-1:0] ch1_merge = {w_strb_r[1] ? w_data_r[15:8] : ch1_in_r[15:8],
                                 w_strb_r[0] ? w_data_r[7:0] : ch1_in_r[7:0]};
    wire [IN_W-1:0] ch2_merge = {w_strb_r[1] ? w_data_r[15:8] : ch2_in_r[15:8],
                                 w_strb_r[0] ? w_data_r[7:0] : ch2_in_r[7:0]};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_held_r     <= 1'b0;
            aw_addr_r     <= '0;
            w_held_r      <= 1'b0;
            w_data_r      <= '0;
            w_strb_r      <= '0;
            ch1_in_r      <= '0;
            ch2_in_r      <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                if (wr_ch1) begin
                    ch1_in_r <= ch1_merge;
                end
                if (wr_ch2) begin
                    ch2_in_r <= ch2_merge;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    wire [DATA_W-1:0] status_w = {25'h0000000, echo_on, ready2, ready1,
                                  busy2, busy1, mode_r};
    wire rd_hit = (s_axi_araddr == ADDR_CH1_INPUT) |
                  (s_axi_araddr == ADDR_CH2_INPUT) |
                  (s_axi_araddr == ADDR_STATUS) |
                  (s_axi_araddr == ADDR_CH1_RESULT) |
                  (s_axi_araddr == ADDR_CH2_RESULT) |
                  (s_axi_araddr == ADDR_CONV_COUNT);
    // Results read sign-extended so software sees a plain signed value.
    wire [DATA_W-1:0] rd_mux =
        (s_axi_araddr == ADDR_CH1_INPUT)  ? {16'h0000, ch1_in_r} :
        (s_axi_araddr == ADDR_CH2_INPUT)  ? {16'h0000, ch2_in_r} :
        (s_axi_araddr == ADDR_STATUS)     ? status_w :
        (s_axi_araddr == ADDR_CH1_RESULT) ? {{17{code1[CODE_W-1]}}, code1} :
        (s_axi_araddr == ADDR_CH2_RESULT) ? {{17{code2[CODE_W-1]}}, code2} :
        (s_axi_araddr == ADDR_CONV_COUNT) ? conv_count_r : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : dsa_top

// [include/dsa_pkg.sv]
// Shared constants and types for the dual converter serial readout block.
package dsa_pkg;
    localparam int CODE_W = 15;
    localparam int IN_W   = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [14:0] CODE_MID   = 15'h4000;
    localparam logic [14:0] CODE_LSB   = 15'h0001;
    localparam logic [14:0] CODE_ZERO  = 15'h0000;
    localparam logic signed [15:0] IN_MAX = 16'sh3fff;
    localparam logic signed [15:0] IN_MIN = 16'shc000;

    localparam logic [7:0] ADDR_CH1_INPUT  = 8'h00;
    localparam logic [7:0] ADDR_CH2_INPUT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_CH1_RESULT = 8'h0c;
    localparam logic [7:0] ADDR_CH2_RESULT = 8'h10;
    localparam logic [7:0] ADDR_CONV_COUNT = 8'h14;

    localparam int ST_MODE_LSB  = 0;
    localparam int ST_BUSY1     = 2;
    localparam int ST_BUSY2     = 3;
    localparam int ST_READY1    = 4;
    localparam int ST_READY2    = 5;
    localparam int ST_ECHO_ON   = 6;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        io_cmos    = 2'b00,
        io_lvds    = 2'b01,
        io_lvds_lp = 2'b10
    } dsa_io_mode_t;

    typedef enum logic [1:0] {
        conv_idle = 2'b00,
        conv_run  = 2'b01,
        conv_done = 2'b10
    } dsa_conv_state_t;
endpackage : dsa_pkg

// [core/dsa_sync2.sv]
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
module dsa_sync2
    import dsa_pkg::*;
#(
    parameter int W = 1
) (
    input  logic         core_clk,
    input  logic         reset,
    input  logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : dsa_sync2

// [core/dsa_sar_chan.sv]
// One successive-approximation channel with sample hold and result code.
`timescale 1ns/1ps
module dsa_sar_chan
    import dsa_pkg::*;
(
    input  logic                   core_clk,
    input  logic                   reset,
    input  logic                   hold,
    input  logic                   step,
    input  logic signed [IN_W-1:0] sample,
    output logic [CODE_W-1:0]      code_r,
    output logic                   busy,
    output logic                   ready
);
    dsa_conv_state_t   state_r;
    logic [CODE_W-1:0] target_r;
    logic [CODE_W-1:0] acc_r;
    logic [CODE_W-1:0] bit_r;

    // Inputs beyond full scale saturate, as the comparator would.
    wire signed [IN_W-1:0] clamped_w = (sample > IN_MAX) ? IN_MAX :
                                       (sample < IN_MIN) ? IN_MIN : sample;
    wire [CODE_W-1:0] offset_w = clamped_w[CODE_W-1:0] ^ CODE_MID;
    wire [CODE_W-1:0] trial_w  = acc_r | bit_r;
    wire [CODE_W-1:0] acc_nxt  = (target_r >= trial_w) ? trial_w : acc_r;
    wire              last_w   = (bit_r == CODE_LSB);

    assign busy  = (state_r == conv_run);
    assign ready = (state_r == conv_done);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r  <= conv_idle;
            target_r <= CODE_ZERO;
            acc_r    <= CODE_ZERO;
            bit_r    <= CODE_ZERO;
            code_r   <= CODE_ZERO;
        end else if (hold) begin
            target_r <= offset_w;
            acc_r    <= CODE_ZERO;
            bit_r    <= CODE_MID;
            state_r  <= conv_run;
        end else begin
            case (state_r)
                conv_run: begin
                    if (step) begin
                        acc_r <= acc_nxt;
                        bit_r <= bit_r >> 1;
                        if (last_w) begin
                            // Back to two's complement.
                            code_r  <= acc_nxt ^ CODE_MID;
                            state_r <= conv_done;
                        end
                    end
                end
                conv_idle: state_r <= conv_idle;
                conv_done: state_r <= conv_done;
                default:   state_r <= conv_idle;
            endcase
        end
    end
endmodule : dsa_sar_chan

// [testbench/dsa_top_sva.sv]
// Pin-level assertions for the dual converter serial readout.
`timescale 1ns/1ps
module dsa_top_sva
    import dsa_pkg::*;
(
    input logic core_clk,
    input logic reset,
    input logic sck_p,
    input logic io_sel_level,
    input logic io_sel_floating,
    input logic ch1_serial_out_p,
    input logic ch1_serial_out_n,
    input logic ch2_serial_out_p,
    input logic ch2_serial_out_n,
    input logic echoed_data_clock_p,
    input logic echoed_data_clock_n_in,
    input logic echoed_data_clock_n_out,
    input logic echoed_data_clock_n_oe
);
    // The negative echo pin drives only in the differential modes.
    wire oe  = echoed_data_clock_n_oe;
    wire sel = io_sel_level | io_sel_floating;
    wire ep  = echoed_data_clock_p;
    wire en  = echoed_data_clock_n_in;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_cmos_neg_idle: assert property (
        !oe |-> !ch1_serial_out_n && !ch2_serial_out_n
            && !echoed_data_clock_n_out) else $error("negative line active");
    a_lvds_data_pair: assert property (
        oe |-> ch1_serial_out_n == !ch1_serial_out_p
            && ch2_serial_out_n == !ch2_serial_out_p) else $error("data pair");
    a_lvds_echo_pair: assert property (
        oe |-> echoed_data_clock_n_out == !ep) else $error("echo pair");
    // Five samples leave room for the pin synchroniser and output register.
    a_sel_lvds_mode: assert property (
        sel [*5] |-> oe) else $error("differential mode not taken");
    a_sel_cmos_mode: assert property (
        !sel [*5] |-> !oe) else $error("single-ended mode not taken");
    a_echo_tied_off: assert property (
        (!sel && en) [*5] |-> !ep) else $error("echo clock not disabled");
    a_echo_follows: assert property (
        $rose(sck_p) && (oe || !en) |-> ##[2:5] ep) else $error("no echo");
    a_echo_skew: assert property (
        $rose(ep) |-> $stable(ch1_serial_out_p) && $stable(ch2_serial_out_p))
        else $error("data moved at echo rise");
endmodule : dsa_top_sva
bind dsa_top dsa_top_sva u_sva (
    .core_clk(core_clk), .reset(reset), .sck_p(sck_p),
    .io_sel_level(io_sel_level), .io_sel_floating(io_sel_floating),
    .ch1_serial_out_p(ch1_serial_out_p), .ch1_serial_out_n(ch1_serial_out_n),
    .ch2_serial_out_p(ch2_serial_out_p), .ch2_serial_out_n(ch2_serial_out_n),
    .echoed_data_clock_p(echoed_data_clock_p),
    .echoed_data_clock_n_in(echoed_data_clock_n_in),
    .echoed_data_clock_n_out(echoed_data_clock_n_out),
    .echoed_data_clock_n_oe(echoed_data_clock_n_oe)
);

// [testbench/dsa_host.sv]
// Host model that starts conversions and captures both result words.
`timescale 1ns/1ps
module dsa_host (
    input  wire logic core_clk,
    input  wire logic lvds,
    input  wire logic use_echo,
    input  wire logic d1,
    input  wire logic d2,
    input  wire logic eclk,
    output logic      conversion_start,
    output logic      sck_p,
    output logic      sck_n
);
    logic [14:0] e1, e2, s1, s2;
    initial begin
        conversion_start <= 1'h1;
        sck_p <= 1'h0;
        sck_n <= 1'h0;
    end
    // The echo rises mid-bit, well away from the data change at its fall.
    always @(posedge eclk) begin
        e1 <= {e1[13:0], d1};
        e2 <= {e2[13:0], d2};
    end
    // Pins move on core clock edges, so the 160 ns link period is 8 cycles.
    task automatic frame(output logic [14:0] w1, output logic [14:0] w2);
        int k;
        conversion_start <= 1'h0;
        repeat (5) @(posedge core_clk);
        for (k = 0; k < 15; k++) begin
            sck_p <= 1'h1;
            sck_n <= !lvds;
            repeat (4) @(posedge core_clk);
            sck_p <= 1'h0;
            sck_n <= lvds;
            // Without the echo the bit is still steady at our own fall.
            s1 = {s1[13:0], d1};
            s2 = {s2[13:0], d2};
            repeat (4) @(posedge core_clk);
        end
        conversion_start <= 1'h1;
        repeat (5) @(posedge core_clk);
        w1 = use_echo ? e1 : s1;
        w2 = use_echo ? e2 : s2;
    endtask : frame
endmodule : dsa_host

// [testbench/dsa_top_bench.sv]
// Self-checking bench: register traffic and serial frames in each mode.
`timescale 1ns/1ps
module dsa_top_bench
    import dsa_pkg::*;
();
    logic        core_clk = 1'h0, reset = 1'h1, lvl = 1'h0, flt = 1'h0;
    logic        tie = 1'h0, lvds = 1'h0, use_echo = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        cs, sp, sn, d1p, d2p, ep, eno, enoe, awr, wr_rdy, bv, arr, rv;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [14:0] w1, w2, p1, p2;
    wire         en_pin = enoe ? eno : tie;
    int          error_cnt = 0, compares = 0, cyc = 0, i;
    logic [15:0] in1 [4] = '{16'h3fff, 16'he000, 16'h0000, 16'h8000};
    logic [15:0] in2 [4] = '{16'hc000, 16'h1fff, 16'h7000, 16'h0001};
    logic [14:0] c1 [4] = '{15'h3fff, 15'h6000, 15'h0000, 15'h4000};
    logic [14:0] c2 [4] = '{15'h4000, 15'h1fff, 15'h3fff, 15'h0001};
    logic [1:0]  md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    dsa_top uut (
        .core_clk(core_clk), .reset(reset), .conversion_start(cs),
        .sck_p(sp), .sck_n(sn), .io_sel_level(lvl), .io_sel_floating(flt),
        .ch1_serial_out_p(d1p), .ch1_serial_out_n(),
        .ch2_serial_out_p(d2p), .ch2_serial_out_n(),
        .echoed_data_clock_p(ep), .echoed_data_clock_n_in(en_pin),
        .echoed_data_clock_n_out(eno), .echoed_data_clock_n_oe(enoe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rready)
    );
    dsa_host host (
        .core_clk(core_clk),
        .lvds(lvds), .use_echo(use_echo), .d1(d1p), .d2(d2p), .eclk(ep),
        .conversion_start(cs), .sck_p(sp), .sck_n(sn)
    );
    always #10 core_clk = ~core_clk;
    task automatic finish_test;
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // A frame and its register traffic take a few hundred cycles at most.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            finish_test;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        // One idle edge keeps bready from being lowered and raised at once.
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awvalid && awr) awvalid <= 1'h0;
            if (wvalid && wr_rdy) wvalid <= 1'h0;
        end while (!bv);
        bready <= 1'h0;
        cmp({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] ed, input logic [1:0] er);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arvalid && arr) arvalid <= 1'h0;
        end while (!rv);
        rready <= 1'h0;
        cmp(rdata & m, ed);
        cmp({30'h0, rresp}, {30'h0, er});
    endtask : rd
    initial begin
        p1 = 15'h0000;
        p2 = 15'h0000;
        repeat (6) @(posedge core_clk);
        reset <= 1'h0;
        repeat (4) @(posedge core_clk);
        rd(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h24, 32'h1, RESP_SLVERR);
        wr(ADDR_CONV_COUNT, 32'h9, RESP_OKAY);
        // Only the low byte lane is enabled, so the upper byte stays zero.
        wstrb <= 4'h1;
        wr(ADDR_CH1_INPUT, 32'h5aa5, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_CH1_INPUT, 32'hffffffff, 32'ha5, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            lvl <= (i == 1) || (i == 2);
            flt <= (i == 2);
            tie <= (i == 3);
            lvds <= (i == 1) || (i == 2);
            use_echo <= (i != 3);
            wr(ADDR_CH1_INPUT, {16'h0, in1[i]}, RESP_OKAY);
            wr(ADDR_CH2_INPUT, {16'h0, in2[i]}, RESP_OKAY);
            rd(ADDR_STATUS, 32'h7f, {25'h0, i != 3, i != 0, i != 0, 2'h0,
               md[i]}, RESP_OKAY);
            host.frame(w1, w2);
            @(posedge core_clk);
            cmp({17'h0, w1}, {17'h0, p1});
            cmp({17'h0, w2}, {17'h0, p2});
            rd(ADDR_CH1_RESULT, 32'hffffffff, {{17{c1[i][14]}}, c1[i]},
               RESP_OKAY);
            rd(ADDR_CH2_RESULT, 32'hffffffff, {{17{c2[i][14]}}, c2[i]},
               RESP_OKAY);
            p1 = c1[i];
            p2 = c2[i];
        end
        host.frame(w1, w2);
        @(posedge core_clk);
        cmp({17'h0, w1}, {17'h0, p1});
        cmp({17'h0, w2}, {17'h0, p2});
        rd(ADDR_CONV_COUNT, 32'hffffffff, 32'h5, RESP_OKAY);
        finish_test;
    end
endmodule : dsa_top_bench
